//--- pkg/ccc_pkg.sv
// Package for the counter based code converter collection.
// Assumes one 50 MHz clock and an active low asynchronous reset.
package ccc_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int BCD5_W   = 20;
  localparam int BIN17_W  = 17;
  localparam int ANG_W    = 12;
  localparam int DIG4_W   = 16;
  localparam int GRAY_W   = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 50;
  localparam int CONV_LIMIT_MS  = 33;
  localparam int CONV_LIMIT_CYC = CONV_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int DIGIT_CYC      = 4096;
  localparam int DIGIT_CNT_W    = 12;
  localparam int RATE_W         = 8;
  localparam int FIFO_DEPTH     = 32;

  // ----------------------------------------------------------------------
  // Constants of the codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] XS3_ADD    = 4'h3;
  localparam logic [3:0] XS3_SUB    = 4'hD;
  localparam logic [3:0] NINE       = 4'h9;
  localparam logic [2:0] RATE_SLOT  = 3'h7;
  localparam logic [7:0] RATE_TERM  = 8'hFF;

  typedef enum logic [1:0] {CCC_IDLE, CCC_LOAD, CCC_RUN} ccc_state_t;

endpackage

//--- rtl/ccc_fifo.sv
// Synchronous FIFO for converted results.
// Assumes both sides share ref_clk; writes while full are refused.
module ccc_fifo
  import ccc_pkg::*;
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign next_rd_ptr = rd_ptr + AW'(pop);
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);

  // The head word is registered so the data output comes from a
  // flip-flop; a word written into an emptying buffer is bypassed.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
    if (push && next_rd_ptr == wr_ptr) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[next_rd_ptr];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count     <= next_count;
      in_ready  <= (next_count != (AW+1)'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end

endmodule

//--- rtl/ccc_top.sv
// Counter based code converters with Gray, Excess-3 Gray and nines
// complement helpers. Assumes a debounced push button; button, mode and
// serial bit pins are synchronised, data words must stay steady while they are used.
//
// Notes on behaviour
// - Input loads a down counter; up counter in target code tracks it.
// - Five BCD digits convert to 17-bit binary well inside 33 ms.
// - Two-stage start ignores a held button, gives one-cycle load and clear pulse.
// - Idle: both stages clear; press sets stage one, asserts load and presets toggle.
// - Next edge sets stage two, drops load, raises busy, lets toggle run.
// - Counters step at half the clock rate until down counter is zero.
// - Terminal count freezes the toggle; stage two resets after release.
// - Every input in range converts correctly, zero included.
// - Angle input 12 bits, top bit 180 degrees, output 0.0 to 359.9.
// - Cycle start loads inverted input into binary counter, clears decimal.
// - Plain mode: decimal counter steps once per binary counter pulse.
// - Display four digits, most significant first, 4096 clocks each.
// - Angle mode inhibits decimal counter 31 of every 256 pulses.
// - Inhibits decode every eighth state of mod-256 counter except terminal.
// - Serial Gray to binary is one toggle on each one, MSB first.
// - Serial binary to Gray XORs current and one-bit delayed bit.
// - Parallel Gray and binary converters are XOR chains.
// - Excess-3 Gray adds three then encodes; decoding adds thirteen.
// - Nines complement gives nine minus the digit.
// - Complement control selects complement or pass-through.
module ccc_top
  import ccc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               start_button,
  input  wire logic [BCD5_W-1:0]  bcd_in,
  output logic      [BIN17_W-1:0] bin_out,
  output logic                    busy,
  output logic                    result_valid,
  input  wire logic               result_ready,
  output logic      [BIN17_W-1:0] result_data,
  input  wire logic [ANG_W-1:0]   ang_in,
  input  wire logic               angle_mode,
  output logic      [DIG4_W-1:0]  disp_bcd,
  output logic      [3:0]         digit_enable,
  output logic      [3:0]         digit_value,
  input  wire logic               ser_gray_in,
  input  wire logic               ser_bin_in,
  input  wire logic               ser_first,
  output logic                    ser_bin_out,
  output logic                    ser_gray_out,
  input  wire logic [GRAY_W-1:0]  par_word,
  output logic      [GRAY_W-1:0]  par_gray_to_bin,
  output logic      [GRAY_W-1:0]  par_bin_to_gray,
  input  wire logic [3:0]         dec_digit,
  output logic      [3:0]         xs3_gray,
  input  wire logic [3:0]         xs3_gray_in,
  output logic      [3:0]         xs3_decoded,
  input  wire logic               complement,
  output logic      [3:0]         nines_out
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [GRAY_W-1:0] to_gray(input logic [GRAY_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic logic [GRAY_W-1:0] from_gray(
    input logic [GRAY_W-1:0] g
  );
    logic [GRAY_W-1:0] b;
    b[GRAY_W-1] = g[GRAY_W-1];
    for (int i = GRAY_W-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       btn;
  logic       mode;
  logic       sg;
  logic       sb;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {ser_bin_in, ser_gray_in, angle_mode, start_button};
      sync2 <= sync1;
    end
  end
  assign {sb, sg, mode, btn} = sync2;

  // The serial word marker comes from our own clock, so these stages
  // only line it up with the synchronised serial bits; without them the
  // marker would clear the serial state two bits too early.
  logic [1:0] first_dly;
  logic       first;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      first_dly <= 2'h0;
    end else begin
      first_dly <= {first_dly[0], ser_first};
    end
  end
  assign first = first_dly[1];

  // ----------------------------------------------------------------------
  // Start stages and BCD-to-binary converter
  // ----------------------------------------------------------------------
  logic                stage2;
  logic                toggle;
  logic [BCD5_W-1:0]   dec_cnt;
  logic [BIN17_W-1:0]  bin_cnt;
  logic                load;
  logic                down_counter_terminal;
  logic                result_push;

  // load pulse: stage one is the synchronised button, one cycle wide.
  assign load = btn && !stage2;
  assign down_counter_terminal = (dec_cnt == '0);

  // start stages: stage two sets after the press and
  // clears only once counting ended and the button is up.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stage2 <= 1'b0;
    end else if (load) begin
      stage2 <= 1'b1;
    end else if (down_counter_terminal && !toggle && !btn) begin
      stage2 <= 1'b0;
    end
  end

  // half rate toggle, held clear at terminal count.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      toggle <= 1'b0;
    end else if (load) begin
      toggle <= 1'b1;
    end else if (down_counter_terminal && !toggle) begin
      toggle <= 1'b0;
    end else begin
      toggle <= !toggle;
    end
  end

  // decimal down counter and binary up counter in step.
  // A digit at zero borrows from the one above and wraps to nine; the
  // loop stops at the first digit that can pay the borrow.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dec_cnt <= '0;
      bin_cnt <= '0;
    end else if (load) begin
      dec_cnt <= bcd_in;
      bin_cnt <= '0;
    end else if (toggle && !down_counter_terminal) begin
      bin_cnt <= bin_cnt + 1'b1;
      for (int d = 0; d < 5; d++) begin
        if (dec_cnt[4*d +: 4] != 4'h0) begin
          dec_cnt[4*d +: 4] <= dec_cnt[4*d +: 4] - 4'h1;
          break;
        end else begin
          dec_cnt[4*d +: 4] <= NINE;
        end
      end
    end
  end

  // busy ends when frozen; frozen value becomes the result.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy        <= 1'b0;
      bin_out     <= '0;
      result_push <= 1'b0;
    end else begin
      result_push <= 1'b0;
      if (load) begin
        busy <= 1'b1;
      end else if (busy && down_counter_terminal && !toggle) begin
        busy        <= 1'b0;
        bin_out     <= bin_cnt;
        result_push <= 1'b1;
      end
    end
  end

  ccc_fifo #(
    .WIDTH (BIN17_W),
    .DEPTH (FIFO_DEPTH)
  ) u_ccc_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (result_push),
    .in_ready  (),
    .in_data   (bin_out),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  // ----------------------------------------------------------------------
  // Binary or angle to BCD converter with display
  // ----------------------------------------------------------------------
  logic [ANG_W-1:0]       abin;
  logic [DIG4_W-1:0]      adec;
  logic [RATE_W-1:0]      rate;
  logic [DIGIT_CNT_W-1:0] dwell;
  logic [1:0]             digit_sel;
  logic                   aconv;
  logic                   inhibit;

  // every eighth state except the terminal state gives 31 inhibits.
  assign inhibit = (rate[2:0] == RATE_SLOT) && (rate != RATE_TERM);

  // load complement, count to terminal, rate-gate.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      abin  <= '1;
      adec  <= '0;
      rate  <= '0;
      aconv <= 1'b0;
    end else if (!aconv) begin
      abin  <= ~ang_in;
      adec  <= '0;
      rate  <= '0;
      aconv <= 1'b1;
    end else if (abin != '1) begin
      abin <= abin + 1'b1;
      rate <= rate + 1'b1;
      if (!(mode && inhibit)) begin
        for (int d = 0; d < 4; d++) begin
          if (adec[4*d +: 4] != NINE) begin
            adec[4*d +: 4] <= adec[4*d +: 4] + 4'h1;
            break;
          end else begin
            adec[4*d +: 4] <= 4'h0;
          end
        end
      end
    end else if (dwell == '1 && digit_sel == 2'h3) begin
      aconv <= 1'b0;
    end
  end

  // show each digit for 4096 clocks, most significant first.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dwell        <= '0;
      digit_sel    <= 2'h0;
      digit_enable <= 4'h0;
      digit_value  <= 4'h0;
      disp_bcd     <= '0;
    end else if (aconv && abin == '1) begin
      dwell        <= dwell + 1'b1;
      disp_bcd     <= adec;
      digit_enable <= 4'h8 >> digit_sel;
      digit_value  <= adec[4*(3-digit_sel) +: 4];
      if (dwell == '1) begin
        digit_sel <= digit_sel + 2'h1;
      end
    end else begin
      // Dark while a new value is counted in, so that the least
      // significant digit is not lit longer than the others.
      digit_enable <= 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Serial and parallel Gray, Excess-3 Gray, nines complement
  // ----------------------------------------------------------------------
  logic prev_bin;

  // toggle on each one, cleared at the MSB; one-bit delay.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ser_bin_out  <= 1'b0;
      ser_gray_out <= 1'b0;
      prev_bin     <= 1'b0;
    end else begin
      ser_bin_out  <= (first ? 1'b0 : ser_bin_out) ^ sg;
      ser_gray_out <= sb ^ (first ? 1'b0 : prev_bin);
      prev_bin     <= sb;
    end
  end

  // combinational codes, registered at the outputs.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      par_gray_to_bin <= '0;
      par_bin_to_gray <= '0;
      xs3_gray        <= 4'h0;
      xs3_decoded     <= 4'h0;
      nines_out       <= 4'h0;
    end else begin
      par_gray_to_bin <= from_gray(par_word);
      par_bin_to_gray <= to_gray(par_word);
      xs3_gray        <= 4'(to_gray(GRAY_W'(dec_digit + XS3_ADD)));
      xs3_decoded     <= 4'(from_gray(GRAY_W'(xs3_gray_in))) + XS3_SUB;
      nines_out       <= complement ? NINE - dec_digit : dec_digit;
    end
  end

endmodule

//--- testbench/ccc_asserts.sv
// Port level checker for the code converter top module.
// Assumes it is bound to ccc_top and sees only its ports.
module ccc_asserts
  import ccc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               resetn,
  input wire logic               start_button,
  input wire logic               busy,
  input wire logic [BIN17_W-1:0] bin_out,
  input wire logic [3:0]         digit_enable,
  input wire logic [GRAY_W-1:0]  par_word,
  input wire logic [GRAY_W-1:0]  par_gray_to_bin,
  input wire logic [GRAY_W-1:0]  par_bin_to_gray,
  input wire logic [3:0]         dec_digit,
  input wire logic [3:0]         xs3_gray,
  input wire logic [3:0]         xs3_gray_in,
  input wire logic [3:0]         xs3_decoded,
  input wire logic               complement,
  input wire logic [3:0]         nines_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        alive;
  logic [3:0]  prev_de;
  logic [15:0] dwell;
  function automatic logic [7:0] g2b(input logic [7:0] g);
    logic [7:0] b;
    b[7] = g[7];
    for (int i = 6; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction
  function automatic logic [3:0] b2g(input logic [3:0] s);
    return s ^ (s >> 1);
  endfunction
  // Outputs right after reset still show reset values, so wait one edge.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) alive <= 1'b0;
    else alive <= 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    prev_de <= digit_enable;
    dwell <= (digit_enable != prev_de) ? 16'h0000 : dwell + 16'h0001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_par_b2g_map: assert property (alive |-> par_bin_to_gray ==
    ($past(par_word) ^ ($past(par_word) >> 1))) else $error("b2g");
  a_par_g2b_map: assert property (alive |->
    par_gray_to_bin == g2b($past(par_word))) else $error("g2b");
  a_xs3_enc_map: assert property (alive |->
    xs3_gray == b2g($past(dec_digit) + XS3_ADD)) else $error("xs3 enc");
  a_xs3_dec_map: assert property (alive |-> xs3_decoded ==
    4'(g2b({4'h0, $past(xs3_gray_in)}) + XS3_SUB)) else $error("xs3 dec");
  a_nines_sel: assert property (alive |-> nines_out ==
    ($past(complement) ? NINE - $past(dec_digit) : $past(dec_digit)))
    else $error("nines");
  a_digit_onehot: assert property ($onehot0(digit_enable))
    else $error("digit enables");
  a_digit_order: assert property ($changed(digit_enable) &&
    $past(digit_enable) != 4'h0 && digit_enable != 4'h0 |->
    digit_enable == {$past(digit_enable[0]), $past(digit_enable[3:1])})
    else $error("digit order");
  a_digit_dwell: assert property (digit_enable != prev_de &&
    prev_de != 4'h0 |-> dwell == 16'(DIGIT_CYC - 1)) else $error("dwell");
  a_result_frozen: assert property (!busy && !$past(busy) &&
    !$past(busy, 2) |-> $stable(bin_out)) else $error("result moved");
  a_busy_start: assert property ($rose(busy) |->
    $past(start_button, 3)) else $error("busy without press");
  c_busy_run: cover property ($rose(busy));
  c_digit_wrap: cover property ($past(digit_enable) == 4'h1 &&
    digit_enable == 4'h0);
  c_compl: cover property (complement && dec_digit != NINE - dec_digit);
endmodule

//--- testbench/ccc_partner.sv
// Operator and result consumer standing at the far side of the block.
// Assumes the bench commands presses and stalls between clock edges.
module ccc_partner (
  input  wire logic ref_clk,
  input  wire logic press,
  input  wire logic stall,
  output logic      start_button,
  output logic      result_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  assign start_button = press;
  // A slow consumer: ready only every other cycle, never while stalled.
  always @(posedge ref_clk) ph <= !ph;
  assign result_ready = !stall && ph;
endmodule

//--- testbench/ccc_top_tb.sv
// Self-checking bench for the code converter top module.
// Assumes the checker and partner files are compiled before it.
module ccc_top_tb;
  import ccc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, resetn, start_button, busy, result_valid, result_ready;
  logic angle_mode, ser_gray_in, ser_bin_in, ser_first, ser_bin_out;
  logic ser_gray_out, complement, press = 1'b0, stall = 1'b1;
  logic [BCD5_W-1:0] bcd_in;
  logic [BIN17_W-1:0] bin_out, result_data, exp_q[$];
  logic [ANG_W-1:0] ang_in;
  logic [DIG4_W-1:0] disp_bcd;
  logic [3:0] digit_enable, digit_value, dec_digit, xs3_gray, xs3_gray_in;
  logic [3:0] xs3_decoded, nines_out;
  logic [GRAY_W-1:0] par_word, par_gray_to_bin, par_bin_to_gray;
  int fail_count = 0, comparisons = 0, cyc = 0;
  ccc_top u_ccc_top (.*);
  ccc_partner u_ccc_partner (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Runs end well before this; reaching it means a hang.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic convert(input logic [19:0] bcd, input int val);
    int k;
    bcd_in = bcd;
    press = 1'b1;
    for (k = 0; busy !== 1'b1 && k < 20; k++) tick();
    check(busy, 1'b1);
    for (k = 0; busy === 1'b1 && k < 30000; k++) tick();
    check(k >= 2 * val && k <= 2 * val + 8, 1'b1);
    check(bin_out, val);
    tick(6);
    check(busy, 1'b0);
    press = 1'b0;
    tick(4);
    if (exp_q.size() < FIFO_DEPTH) exp_q.push_back(val[16:0]);
  endtask
  task automatic drain();
    stall = 1'b0;
    repeat (300) begin
      @(posedge ref_clk);
      if (result_valid === 1'b1 && result_ready === 1'b1)
        check(result_data, exp_q.size() ? exp_q.pop_front() : '1);
    end
    #1;
    check(exp_q.size(), 0);
    check(result_valid, 1'b0);
  endtask
  task automatic codes();
    logic [3:0] xg[10] = '{4'h2, 4'h6, 4'h7, 4'h5, 4'h4,
                           4'hC, 4'hD, 4'hF, 4'hE, 4'hA};
    for (int i = 0; i < 20; i++) begin
      dec_digit = 4'(i % 10);
      complement = i >= 10;
      xs3_gray_in = xg[i % 10];
      par_word = {dec_digit, xs3_gray_in};
      tick(2);
      check(xs3_gray, xg[i % 10]);
      check(xs3_decoded, dec_digit);
      check(nines_out, complement ? 9 - i % 10 : i % 10);
      check(par_bin_to_gray, par_word ^ (par_word >> 1));
      check(par_gray_to_bin ^ (par_gray_to_bin >> 1), par_word);
    end
  endtask
  // serial words, MSB first; results trail by three edges
  task automatic serial(input logic [7:0] b, input logic [7:0] g);
    for (int j = 0; j < 10; j++) begin
      if (j < 8) begin
        ser_gray_in = g[7-j];
        ser_bin_in = b[7-j];
      end
      ser_first = (j == 0);
      tick();
      if (j >= 2) begin
        check(ser_bin_out, b[9-j]);
        check(ser_gray_out, g[9-j]);
      end
    end
  endtask
  // new input shows on the next sweep
  task automatic show(input logic m, input logic [11:0] a,
                      input logic [15:0] exp);
    int k;
    angle_mode = m;
    ang_in = a;
    for (k = 0; digit_enable !== 4'h1 && k < 40000; k++) tick();
    for (k = 0; digit_enable !== 4'h8 && k < 40000; k++) tick();
    tick(2);
    check(disp_bcd, exp);
    check(digit_value, exp[15:12]);
  endtask
  initial begin
    resetn = 1'b0;
    {bcd_in, ang_in, angle_mode, complement, dec_digit} = '0;
    {xs3_gray_in, par_word, ser_gray_in, ser_bin_in, ser_first} = '0;
    repeat (20) @(posedge ref_clk);
    #1 resetn = 1'b1;
    tick(2);
    codes();
    serial(8'h4B, 8'h6E);
    serial(8'hB4, 8'hEE);
    convert(20'h00000, 0);
    convert(20'h00009, 9);
    convert(20'h00010, 10);
    convert(20'h01234, 1234);
    // Stalled consumer: the buffer fills and later results are dropped.
    for (int i = 0; i < 34; i++) convert(20'(i % 10), i % 10);
    drain();
    show(1'b0, 12'd1234, 16'h1234);
    show(1'b1, 12'h800, 16'h1800);
    stop_test();
  end
endmodule
bind ccc_top ccc_asserts u_ccc_asserts (.ref_clk, .resetn, .start_button,
  .busy, .bin_out, .digit_enable, .par_word, .par_gray_to_bin,
  .par_bin_to_gray, .dec_digit, .xs3_gray, .xs3_gray_in, .xs3_decoded,
  .complement, .nines_out);
